// ---- rtl/rtcsa_top.sv ----
// Two-wire slave access, clock freeze, supervisor and tamper logic
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Addressed read: write word address, repeated START, then device address with read.
// RULE_02: During reads the pointer advances only on an acknowledged ack clock.
// RULE_03: Consecutive bytes are sent while the master acknowledges, until STOP.
// RULE_04: Pointer in clock locations 00h to 07h freezes the user clock copy.
// RULE_05: User copy updates again on STOP or pointer leaving the clock range.
// RULE_06: Read without loading pointer starts from the last stored pointer.
// RULE_07: Write sends word address first; device loads it into the pointer.
// RULE_08: Each written byte is stored at pointer; pointer advances on ack clock.
// RULE_09: Device acknowledges device address, word address and every data byte.
// RULE_10: Supply fail deselects the device and blocks every register write.
// RULE_11: Supply fail drives the active-low reset output until supply recovers.
// RULE_12: Out of tolerance, external memory enable is held inactive high.
// RULE_13: Below switchover, battery keeps clock registers and external memory alive.
// RULE_14: In battery backup all signal outputs go high impedance.
// RULE_15: After recovery, enable gating and reset persist for the recovery interval.
// RULE_16: Each tamper input sets its own flag only if its enable is set.
// RULE_17: Connect mode and polarity bits choose which switch change is the event.
// RULE_18: Supply fail aborts any transfer and resets the address pointer.
// RULE_19: User RAM occupies 20h to 9Fh, after the other locations.
// RULE_20: Master withholds ack after last byte; device releases data line high.
// RULE_21: Internal counters keep running while frozen; resume refreshes the user copy.
module rtcsa_top
  import rtcsa_pkg::*;
#(
  parameter int REC_CYCLES = rtcsa_pkg::RTCSA_REC_CYCLES
)(
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  input  wire logic power_fail,
  input  wire logic battery_mode,
  input  wire logic osc_tick,
  input  wire logic ext_enable_n,
  output logic      external_mem_enable_n,
  output logic      mem_enable_oe_n,
  output logic      reset_out_n,
  output logic      reset_out_oe_n,
  input  wire logic tamper_input_one,
  input  wire logic tamper_input_two
);
  import rtcsa_pkg::*;

  // Recovery count must fit the counter and be nonzero
  if (REC_CYCLES < 1 || REC_CYCLES >= (1 << RTCSA_REC_WIDTH))
  begin : g_bad_rec
    $error("REC_CYCLES out of range");
  end

  logic [RTCSA_SYNC_W-1:0]    sync1;
  logic [RTCSA_SYNC_W-1:0]    sync2;
  logic                       scl_s;
  logic                       sda_s;
  logic                       pf_s;
  logic                       batt_s;
  logic                       tick_s;
  logic                       exen_s;
  logic                       tp1_s;
  logic                       tp2_s;
  logic                       scl_prev;
  logic                       sda_prev;
  logic                       tick_prev;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       start_c;
  logic                       stop_c;
  logic                       tick_rise;

  rtcsa_state_t               state;
  rtcsa_state_t               next_state;
  logic [3:0]                 bit_cnt;
  logic [3:0]                 next_bit_cnt;
  logic [7:0]                 shreg;
  logic [7:0]                 next_shreg;
  logic [7:0]                 ptr;
  logic [7:0]                 next_ptr;
  logic                       rw;
  logic                       next_rw;
  logic                       drive;
  logic                       next_drive;
  logic                       wr_en;

  logic [7:0]                 mem [0:RTCSA_MAP_BYTES-1];
  logic [63:0]                time_count;
  logic [63:0]                next_time_count;
  logic                       frozen;

  logic                       flag1;
  logic                       flag2;
  logic                       next_flag1;
  logic                       next_flag2;
  logic                       ev1;
  logic                       ev2;

  logic [RTCSA_REC_WIDTH-1:0] rec_cnt;
  logic [RTCSA_REC_WIDTH-1:0] next_rec_cnt;
  logic                       inhibit;
  logic                       next_reset_out_n;
  logic                       next_mem_en_n;

  // Pointer step; past the top of the map it wraps to zero
  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = (p >= RTCSA_MAP_LAST) ? RTCSA_PTR_RESET : p + 8'h01;
  endfunction

  // Byte seen by the master at an address
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [7:0] b;
    b = 8'h00;
    if (a <= RTCSA_MAP_LAST)
      b = mem[a];
    if (a == RTCSA_FLAGS_ADDR)
    begin
      b[RTCSA_FLAG_T1_BIT] = flag1;
      b[RTCSA_FLAG_T2_BIT] = flag2;
    end
    read_byte = b;
  endfunction

  // Event when the pin reaches the polarity level (open) or leaves it (closed)
  function automatic logic tamper_event(input logic pin, input logic [7:0] ctl);
    tamper_event = ctl[RTCSA_TCM_BIT] ? (pin == ctl[RTCSA_TPM_BIT])
                                      : (pin != ctl[RTCSA_TPM_BIT]);
  endfunction

  assign {scl_s, sda_s, pf_s, batt_s, tick_s, exen_s, tp1_s, tp2_s} = sync2;
  assign scl_rise  = scl_s & ~scl_prev;
  assign scl_fall  = ~scl_s & scl_prev;
  assign start_c   = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_c    = scl_s & scl_prev & ~sda_prev & sda_s;
  assign tick_rise = tick_s & ~tick_prev;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1     <= '0;
      sync2     <= '0;
      scl_prev  <= 1'b1;
      sda_prev  <= 1'b1;
      tick_prev <= 1'b0;
    end
    else
    begin
      sync1     <= {scl, sda_in, power_fail, battery_mode, osc_tick,
                    ext_enable_n, tamper_input_one, tamper_input_two};
      sync2     <= sync1;
      scl_prev  <= scl_s;
      sda_prev  <= sda_s;
      tick_prev <= tick_s;
    end
  end

  // Supervisor: reset and memory enable gating
  assign inhibit = pf_s | (rec_cnt != '0);

  always_comb
  begin
    next_rec_cnt = rec_cnt;
    if (pf_s)
      next_rec_cnt = RTCSA_REC_WIDTH'(REC_CYCLES);                       // [RULE_15]
    else if (rec_cnt != '0)
      next_rec_cnt = rec_cnt - 1'b1;                                     // [RULE_15]
    next_reset_out_n = ~inhibit;                                         // [RULE_11]
    next_mem_en_n    = exen_s | inhibit;                                 // [RULE_12]
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rec_cnt               <= RTCSA_REC_WIDTH'(REC_CYCLES);
      reset_out_n           <= 1'b0;
      external_mem_enable_n <= 1'b1;
    end
    else
    begin
      rec_cnt               <= next_rec_cnt;
      reset_out_n           <= next_reset_out_n;
      external_mem_enable_n <= next_mem_en_n;
    end
  end

  // Battery backup releases every driven output
  assign reset_out_oe_n  = batt_s;                                       // [RULE_14]
  assign mem_enable_oe_n = batt_s;                                       // [RULE_14]
  assign sda_oe_n        = ~drive | batt_s;                              // [RULE_14]
  assign sda_out         = 1'b0;

  // Two-wire slave engine
  always_comb
  begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    next_ptr     = ptr;
    next_rw      = rw;
    next_drive   = drive;
    wr_en        = 1'b0;
    if (inhibit)
    begin
      next_state   = RTCSA_IDLE;                                         // [RULE_18] [RULE_10]
      next_bit_cnt = '0;
      next_drive   = 1'b0;
      next_ptr     = RTCSA_PTR_RESET;                                    // [RULE_18]
    end
    else if (start_c)
    begin
      next_state   = RTCSA_ADDR;                                         // [RULE_01]
      next_bit_cnt = '0;
      next_drive   = 1'b0;
    end
    else if (stop_c)
    begin
      next_state = RTCSA_IDLE;                                           // [RULE_03]
      next_drive = 1'b0;
    end
    else
    begin
      case (state)
        RTCSA_ADDR, RTCSA_WADDR, RTCSA_WDATA:
        begin
          if (scl_rise)
          begin
            next_shreg   = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == RTCSA_BYTE_BITS)
          begin
            next_bit_cnt = '0;
            next_drive   = 1'b1;                                         // [RULE_09]
            if (state == RTCSA_ADDR)
            begin
              if (shreg[7:1] == RTCSA_DEV_ADDR)
              begin
                next_rw    = shreg[0];
                next_state = RTCSA_ADDR_ACK;
              end
              else
              begin
                next_drive = 1'b0;
                next_state = RTCSA_IDLE;
              end
            end
            else if (state == RTCSA_WADDR)
            begin
              next_ptr   = shreg;                                        // [RULE_07]
              next_state = RTCSA_WADDR_ACK;
            end
            else
            begin
              wr_en      = 1'b1;                                         // [RULE_08]
              next_state = RTCSA_WDATA_ACK;
            end
          end
        end
        RTCSA_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw)
            begin
              next_shreg = read_byte(ptr);                               // [RULE_06] [RULE_01]
              next_drive = ~next_shreg[7];
              next_state = RTCSA_RDATA;
            end
            else
            begin
              next_drive = 1'b0;
              next_state = RTCSA_WADDR;                                  // [RULE_07]
            end
          end
        end
        RTCSA_WADDR_ACK:
        begin
          if (scl_fall)
          begin
            next_drive = 1'b0;
            next_state = RTCSA_WDATA;
          end
        end
        RTCSA_WDATA_ACK:
        begin
          if (scl_rise)
            next_ptr = ptr_inc(ptr);                                     // [RULE_08]
          else if (scl_fall)
          begin
            next_drive = 1'b0;
            next_state = RTCSA_WDATA;
          end
        end
        RTCSA_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == RTCSA_LAST_TX_BIT)
            begin
              next_bit_cnt = '0;
              next_drive   = 1'b0;
              next_state   = RTCSA_RDATA_ACK;
            end
            else
            begin
              next_shreg   = {shreg[6:0], 1'b0};
              next_drive   = ~shreg[6];
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        RTCSA_RDATA_ACK:
        begin
          if (scl_rise)
          begin
            if (!sda_s)
              next_ptr = ptr_inc(ptr);                                   // [RULE_02]
            else
              next_state = RTCSA_IDLE;                                   // [RULE_20]
          end
          else if (scl_fall)
          begin
            next_shreg = read_byte(ptr);                                 // [RULE_03]
            next_drive = ~next_shreg[7];
            next_state = RTCSA_RDATA;
          end
        end
        default:
        begin
          next_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state   <= RTCSA_IDLE;
      bit_cnt <= '0;
      shreg   <= 8'h00;
      ptr     <= RTCSA_PTR_RESET;
      rw      <= 1'b0;
      drive   <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
      ptr     <= next_ptr;
      rw      <= next_rw;
      drive   <= next_drive;
    end
  end

  // Clock counters run on regardless of the frozen user copy
  assign frozen = (state != RTCSA_IDLE) && (ptr <= RTCSA_CLOCK_LAST);  // [RULE_04] [RULE_05]

  always_comb
  begin
    next_time_count = time_count;
    if (tick_rise)
      next_time_count = time_count + 64'h1;                              // [RULE_21] [RULE_13]
    if (wr_en && ptr <= RTCSA_CLOCK_LAST)
      next_time_count[ptr[2:0]*8 +: 8] = shreg;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      time_count <= 64'h0;
    else
      time_count <= next_time_count;
  end

  // Register map storage; user RAM at the top
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < RTCSA_MAP_BYTES; i++)
        mem[i] <= RTCSA_MEM_RESET;
    end
    else
    begin
      if (wr_en && ptr <= RTCSA_MAP_LAST)
        mem[ptr] <= shreg;                                               // [RULE_08] [RULE_19]
      if (!frozen)
      begin
        for (int i = 0; i < RTCSA_CLOCK_BYTES; i++)
          mem[i] <= time_count[i*8 +: 8];                                // [RULE_05] [RULE_21]
      end
    end
  end

  // Tamper flags: set by events, cleared only by dropping the enable
  assign ev1 = tamper_event(tp1_s, mem[RTCSA_TAMP1_ADDR]);               // [RULE_17]
  assign ev2 = tamper_event(tp2_s, mem[RTCSA_TAMP2_ADDR]);               // [RULE_17]

  always_comb
  begin
    next_flag1 = mem[RTCSA_TAMP1_ADDR][RTCSA_TEN_BIT] & (flag1 | ev1);   // [RULE_16]
    next_flag2 = mem[RTCSA_TAMP2_ADDR][RTCSA_TEN_BIT] & (flag2 | ev2);   // [RULE_16]
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag1 <= 1'b0;
      flag2 <= 1'b0;
    end
    else
    begin
      flag1 <= next_flag1;
      flag2 <= next_flag2;
    end
  end
endmodule // rtcsa_top

// ---- include/rtcsa_pkg.sv ----
// Shared constants and types of the serial access and retention block
package rtcsa_pkg;
  // Two-wire device address, seven bits
  localparam logic [6:0] RTCSA_DEV_ADDR      = 7'h68;
  // Address map
  localparam logic [7:0] RTCSA_CLOCK_LAST    = 8'h07;
  localparam logic [7:0] RTCSA_FLAGS_ADDR    = 8'h0f;
  localparam logic [7:0] RTCSA_TAMP1_ADDR    = 8'h14;
  localparam logic [7:0] RTCSA_TAMP2_ADDR    = 8'h15;
  localparam logic [7:0] RTCSA_RAM_FIRST     = 8'h20;
  localparam logic [7:0] RTCSA_MAP_LAST      = 8'h9f;
  localparam int         RTCSA_MAP_BYTES     = 160;
  localparam int         RTCSA_CLOCK_BYTES   = 8;
  localparam logic [7:0] RTCSA_MEM_RESET     = 8'h00;
  localparam logic [7:0] RTCSA_PTR_RESET     = 8'h00;
  // Tamper control register fields
  localparam int         RTCSA_TEN_BIT       = 7;
  localparam int         RTCSA_TCM_BIT       = 6;
  localparam int         RTCSA_TPM_BIT       = 5;
  // Event flag register fields
  localparam int         RTCSA_FLAG_T1_BIT   = 0;
  localparam int         RTCSA_FLAG_T2_BIT   = 1;
  // Bit count of one byte on the wire
  localparam logic [3:0] RTCSA_BYTE_BITS     = 4'h8;
  localparam logic [3:0] RTCSA_LAST_TX_BIT   = 4'h7;
  // Timing
  localparam int         RTCSA_CLK_HZ        = 40_000_000;
  localparam int         RTCSA_REC_TIME_US   = 200_000;
  localparam int         RTCSA_REC_CYCLES    = RTCSA_REC_TIME_US * (RTCSA_CLK_HZ / 1_000_000);
  localparam int         RTCSA_REC_WIDTH     = 24;
  // Input synchroniser lanes
  localparam int         RTCSA_SYNC_W        = 8;

  typedef enum logic [3:0] {
    RTCSA_IDLE      = 4'b0000,
    RTCSA_ADDR      = 4'b0001,
    RTCSA_ADDR_ACK  = 4'b0010,
    RTCSA_WADDR     = 4'b0011,
    RTCSA_WADDR_ACK = 4'b0100,
    RTCSA_WDATA     = 4'b0101,
    RTCSA_WDATA_ACK = 4'b0110,
    RTCSA_RDATA     = 4'b0111,
    RTCSA_RDATA_ACK = 4'b1000
  } rtcsa_state_t;
endpackage

// ---- bench/rtcsa_assertions.sv ----
// Port-level assertions of the serial access and retention block
`timescale 1ns/1ps
module rtcsa_assertions
#(
  parameter int REC_CYCLES = rtcsa_pkg::RTCSA_REC_CYCLES
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic power_fail,
  input wire logic battery_mode,
  input wire logic osc_tick,
  input wire logic ext_enable_n,
  input wire logic external_mem_enable_n,
  input wire logic mem_enable_oe_n,
  input wire logic reset_out_n,
  input wire logic reset_out_oe_n,
  input wire logic tamper_input_one,
  input wire logic tamper_input_two
);
  int unsigned low_cnt;
  int unsigned next_low_cnt;

  // Cycles since the supply was last seen failing
  always_comb
  begin
    next_low_cnt = low_cnt;
    if (power_fail)
      next_low_cnt = 0;
    else if (low_cnt < REC_CYCLES)
      next_low_cnt = low_cnt + 1;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      low_cnt <= 0;
    else
      low_cnt <= next_low_cnt;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_inhib;
    (!reset_out_n) [*4];
  endsequence
  sequence s_held_low;
    (!reset_out_n) [*8];
  endsequence

  chk_fail_reset: assert property (power_fail |-> ##[1:4] !reset_out_n)
    else $error("reset output not asserted on supply fail");
  chk_fail_gate: assert property (power_fail |-> ##[1:4] external_mem_enable_n)
    else $error("memory enable not gated on supply fail");
  chk_gate_track: assert property (!reset_out_n |-> external_mem_enable_n)
    else $error("memory enable passed during inhibit");
  chk_batt_float: assert property (battery_mode |->
    ##[1:4] (sda_oe_n && mem_enable_oe_n && reset_out_oe_n))
    else $error("outputs still driven in battery mode");
  chk_rec_hold: assert property ($fell(power_fail) |-> ##2 s_held_low)
    else $error("reset released early after recovery");
  chk_rec_time: assert property ($rose(reset_out_n) |-> low_cnt >= REC_CYCLES)
    else $error("recovery interval too short");
  chk_no_ack: assert property (s_inhib |-> sda_oe_n)
    else $error("bus driven while deselected");
  chk_mem_pass: assert property ((reset_out_n && !ext_enable_n) [*4]
    |-> !external_mem_enable_n)
    else $error("memory enable not passed through");
endmodule // rtcsa_assertions

// ---- bench/rtcsa_master.sv ----
// Two-wire bus master model making the link clock and data line
`timescale 1ns/1ps
module rtcsa_master (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Data set in the low phase, sampled while high
  task automatic bit_x(input logic b, output logic r);
    #75 sda_drv = b;
    #75 scl = 1'b1;
    #25 r = sda;
    #25 scl = 1'b0;
  endtask

  // Also serves as repeated start
  task automatic start;
    @(negedge mclk);
    #75 sda_drv = 1'b1;
    #75 scl = 1'b1;
    #150 sda_drv = 1'b0;
    #150 scl = 1'b0;
  endtask

  task automatic stop;
    #75 sda_drv = 1'b0;
    #75 scl = 1'b1;
    #150 sda_drv = 1'b1;
    #150;
  endtask

  // Byte MSB first, then the acknowledge clock
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(mack, ack);
  endtask
endmodule // rtcsa_master

// ---- bench/tb.sv ----
// Self-checking bench of the serial access and retention block
`timescale 1ns/1ps
module tb;
  import rtcsa_pkg::*;
  localparam int REC = 20;
  typedef struct packed { logic [7:0] a; logic [7:0] w; logic [7:0] e; } rtcsa_row_t;
  rtcsa_row_t rows [5] = '{'{8'h00, 8'h00, 8'h00}, '{8'h20, 8'ha5, 8'ha5},
    '{8'h9f, 8'h5a, 8'h5a}, '{8'h0f, 8'hff, 8'hfc}, '{8'ha0, 8'h77, 8'h00}};
  logic mclk = 1'b0;
  logic reset_n, power_fail, battery_mode, osc_tick, ext_enable_n;
  logic tamper_input_one, tamper_input_two;
  logic sda_out, sda_oe_n, external_mem_enable_n, mem_enable_oe_n;
  logic reset_out_n, reset_out_oe_n, scl, sda_drv, ak;
  wire  sda_in;
  logic [7:0] q;
  int fail_count = 0;
  int num_checks = 0;

  always #12.5 mclk = ~mclk;
  // Pull-up wire, released unless someone pulls low
  assign sda_in = sda_drv & (sda_oe_n | sda_out);

  rtcsa_top #(.REC_CYCLES(REC)) dut (.mclk(mclk), .reset_n(reset_n), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .power_fail(power_fail),
    .battery_mode(battery_mode), .osc_tick(osc_tick), .ext_enable_n(ext_enable_n),
    .external_mem_enable_n(external_mem_enable_n), .mem_enable_oe_n(mem_enable_oe_n),
    .reset_out_n(reset_out_n), .reset_out_oe_n(reset_out_oe_n),
    .tamper_input_one(tamper_input_one), .tamper_input_two(tamper_input_two));
  rtcsa_master m (.mclk(mclk), .sda(sda_in), .scl(scl), .sda_drv(sda_drv));

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One byte; where the master releases, the answer bit is checked
  task x(input logic [7:0] d, input logic ma, input logic ea);
    m.xfer(d, ma, q, ak);
    if (ma)
      chk({7'h00, ak}, {7'h00, ea});
  endtask

  task wr_hdr(input logic [7:0] a, input logic ea);
    m.start();
    x({RTCSA_DEV_ADDR, 1'b0}, 1'b1, ea);
    x(a, 1'b1, ea);
  endtask

  task rd_go;
    m.start();
    x({RTCSA_DEV_ADDR, 1'b1}, 1'b1, 1'b0);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    wr_hdr(a, 1'b0);
    x(d, 1'b1, 1'b0);
    m.stop();
  endtask

  task rd(input logic [7:0] a);
    wr_hdr(a, 1'b0);
    rd_go();
    x(8'hff, 1'b1, 1'b1);
    m.stop();
  endtask

  task tick(input int n);
    repeat (n)
    begin
      osc_tick = 1'b1;
      repeat (3) @(negedge mclk);
      osc_tick = 1'b0;
      repeat (3) @(negedge mclk);
    end
  endtask

  task tp(input logic [1:0] ev);
    {tamper_input_two, tamper_input_one} = ~ev;
    repeat (4) @(negedge mclk);
    {tamper_input_two, tamper_input_one} = 2'b11;
    repeat (4) @(negedge mclk);
  endtask

  initial
  begin
    reset_n = 1'b0;
    {power_fail, battery_mode, osc_tick} = 3'b000;
    {ext_enable_n, tamper_input_one, tamper_input_two} = 3'b111;
    repeat (2) @(posedge mclk);
    @(negedge mclk) reset_n = 1'b1;
    chk({6'h00, reset_out_n, external_mem_enable_n}, 8'h01);
    repeat (REC + 8) @(negedge mclk);
    chk({7'h00, reset_out_n}, 8'h01);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(q, rows[i].e);
    end
    wr_hdr(8'h21, 1'b0);
    x(8'h11, 1'b1, 1'b0);
    x(8'h22, 1'b1, 1'b0);
    m.stop();
    wr_hdr(8'h21, 1'b0);
    rd_go();
    x(8'hff, 1'b0, 1'b0);
    chk(q, 8'h11);
    x(8'hff, 1'b1, 1'b1);
    m.stop();
    chk(q, 8'h22);
    rd_go();
    x(8'hff, 1'b1, 1'b1);
    m.stop();
    chk(q, 8'h22);
    tick(3);
    wr_hdr(8'h00, 1'b0);
    fork
      tick(4);
      begin
        rd_go();
        x(8'hff, 1'b1, 1'b1);
        m.stop();
      end
    join
    chk(q, 8'h03);
    rd(8'h00);
    chk(q, 8'h07);
    wr(RTCSA_TAMP1_ADDR, 8'hc0);
    wr(RTCSA_TAMP2_ADDR, 8'h20);
    tp(2'b11);
    rd(RTCSA_FLAGS_ADDR);
    chk(q, 8'hfd);
    wr(RTCSA_TAMP2_ADDR, 8'ha0);
    tp(2'b10);
    rd(RTCSA_FLAGS_ADDR);
    chk(q, 8'hff);
    wr(RTCSA_TAMP1_ADDR, 8'h40);
    rd(RTCSA_FLAGS_ADDR);
    chk(q, 8'hfe);
    {tamper_input_two, tamper_input_one} = 2'b00;
    wr(RTCSA_TAMP2_ADDR, 8'h00);
    wr(RTCSA_TAMP1_ADDR, 8'he0);
    wr(RTCSA_TAMP2_ADDR, 8'h80);
    rd(RTCSA_FLAGS_ADDR);
    chk(q, 8'hfc);
    {tamper_input_two, tamper_input_one} = 2'b11;
    repeat (4) @(negedge mclk);
    rd(RTCSA_FLAGS_ADDR);
    chk(q, 8'hff);
    ext_enable_n = 1'b0;
    repeat (5) @(negedge mclk);
    chk({7'h00, external_mem_enable_n}, 8'h00);
    power_fail = 1'b1;
    repeat (5) @(negedge mclk);
    chk({6'h00, reset_out_n, external_mem_enable_n}, 8'h01);
    wr_hdr(8'h20, 1'b1);
    x(8'h00, 1'b1, 1'b1);
    m.stop();
    battery_mode = 1'b1;
    repeat (5) @(negedge mclk);
    chk({5'h00, sda_oe_n, mem_enable_oe_n, reset_out_oe_n}, 8'h07);
    tick(2);
    {battery_mode, power_fail} = 2'b00;
    repeat (REC - 4) @(negedge mclk);
    chk({7'h00, reset_out_n}, 8'h00);
    repeat (12) @(negedge mclk);
    chk({6'h00, reset_out_n, external_mem_enable_n}, 8'h02);
    rd_go();
    x(8'hff, 1'b1, 1'b1);
    m.stop();
    chk(q, 8'h09);
    rd(8'h20);
    chk(q, 8'ha5);
    conclude();
  end

  initial
  begin
    #1_000_000;
    fail_count++;
    conclude();
  end
endmodule // tb

bind rtcsa_top rtcsa_assertions #(.REC_CYCLES(REC_CYCLES)) u_chk (.mclk(mclk),
  .reset_n(reset_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .power_fail(power_fail), .battery_mode(battery_mode), .osc_tick(osc_tick),
  .ext_enable_n(ext_enable_n), .external_mem_enable_n(external_mem_enable_n),
  .mem_enable_oe_n(mem_enable_oe_n), .reset_out_n(reset_out_n),
  .reset_out_oe_n(reset_out_oe_n), .tamper_input_one(tamper_input_one),
  .tamper_input_two(tamper_input_two));
